// file: hdl/iso_irq_regs.sv
// Isochronous receive channel mask and interrupt event registers with Wishbone access
//
// The Wishbone slave port was decided locally.
module iso_irq_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [iso_irq_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [iso_irq_pkg::SEL_W-1:0] wb_sel_i,
   input wire logic [iso_irq_pkg::DATA_W-1:0] wb_dat_i,
   output logic [iso_irq_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic gp_irq_a_i,
   input wire logic gp_irq_b_i,
   input wire logic rx_fifo_pending_i,
   input wire logic phys_resp_busy_i,
   input wire logic late_ack_sent_i,
   output logic [iso_irq_pkg::DATA_W-1:0] channel_receive_enable_o,
   output logic irq_o
);
   import iso_irq_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] chan_mask;
   logic [DATA_W-1:0] next_chan_mask;
   logic [DATA_W-1:0] events;
   logic [DATA_W-1:0] next_events;
   logic [DATA_W-1:0] int_mask;
   logic [DATA_W-1:0] next_int_mask;
   logic [DATA_W-1:0] control;
   logic [DATA_W-1:0] next_control;

   logic [DATA_W-1:0] wbits;
   logic [DATA_W-1:0] hw_set;
   logic [DATA_W-1:0] sw_set;
   logic [DATA_W-1:0] sw_clr;
   logic [DATA_W-1:0] masked_events;
   logic [DATA_W-1:0] read_value;
   logic [EDGE_W-1:0] source_level;
   logic [EDGE_W-1:0] source_rise;
   logic late_enable;
   logic gp_a_enable;
   logic gp_b_enable;
   logic wr_chan_set;
   logic wr_chan_clr;
   logic wr_ev_set;
   logic wr_ev_clr;
   logic wr_int_mask;
   logic wr_control;

   reg_access_if bus ();

   // ----------------------------------------------------------------
   // Bus front
   // ----------------------------------------------------------------
   wb_front u_front (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .bus(bus.front)
   );

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   assign wbits = bus.wdata & bus.wmask;
   assign wr_chan_set = bus.wr & (bus.addr == OFS_CHAN_MASK_SET);
   assign wr_chan_clr = bus.wr & (bus.addr == OFS_CHAN_MASK_CLEAR);
   assign wr_ev_set = bus.wr & (bus.addr == OFS_EVENT_SET);
   assign wr_ev_clr = bus.wr & (bus.addr == OFS_EVENT_CLEAR);
   assign wr_int_mask = bus.wr & (bus.addr == OFS_INT_MASK);
   assign wr_control = bus.wr & (bus.addr == OFS_CONTROL);

   // ----------------------------------------------------------------
   // Control bits
   // ----------------------------------------------------------------
   assign late_enable = control[CTRL_LATE_EN_BIT];
   assign gp_a_enable = control[CTRL_GP_A_EN_BIT];
   assign gp_b_enable = control[CTRL_GP_B_EN_BIT];

   // ----------------------------------------------------------------
   // Event sources
   // ----------------------------------------------------------------
   always_comb begin
      source_level = {EDGE_W{1'b0}};
      source_level[EDGE_GP] = (gp_irq_a_i & gp_a_enable) | (gp_irq_b_i & gp_b_enable);
      source_level[EDGE_LATE] = late_enable
         & (rx_fifo_pending_i | phys_resp_busy_i | late_ack_sent_i);
   end

   event_edge u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .level_i(source_level),
      .rise_o(source_rise)
   );

   always_comb begin
      hw_set = READ_ZERO;
      hw_set[EV_GP_BIT] = source_rise[EDGE_GP];
      hw_set[EV_LATE_BIT] = source_rise[EDGE_LATE];
      // Software event has no hardware source
      hw_set[EV_SOFT_BIT] = 1'b0;
   end

   // ----------------------------------------------------------------
   // Software set and clear terms
   // ----------------------------------------------------------------
   always_comb begin
      sw_set = READ_ZERO;
      sw_clr = READ_ZERO;
      if (wr_ev_set) begin
         sw_set = wbits & EVENT_IMPL_MASK;
      end
      if (wr_ev_clr) begin
         sw_clr = wbits & EVENT_IMPL_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Next register values
   // ----------------------------------------------------------------
   always_comb begin
      next_chan_mask = chan_mask;
      next_events = events;
      next_int_mask = int_mask;
      next_control = control;
      if (wr_chan_set) begin
         next_chan_mask = set_clear(chan_mask, wbits, READ_ZERO);
      end
      if (wr_chan_clr) begin
         next_chan_mask = set_clear(chan_mask, READ_ZERO, wbits);
      end
      // Hardware or software set wins over a clear in the same cycle
      next_events = set_clear(events, hw_set | sw_set, sw_clr) & EVENT_IMPL_MASK;
      if (wr_int_mask) begin
         next_int_mask = merge(int_mask, bus.wdata, bus.wmask) & EVENT_IMPL_MASK;
      end
      if (wr_control) begin
         next_control = merge(control, bus.wdata, bus.wmask) & CTRL_IMPL_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_mask <= CHAN_MASK_RESET;
         events <= EVENT_RESET;
         int_mask <= INT_MASK_RESET;
         control <= CONTROL_RESET;
      end else if (ce_i) begin
         chan_mask <= next_chan_mask;
         events <= next_events;
         int_mask <= next_int_mask;
         control <= next_control;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   assign masked_events = events & int_mask & EVENT_IMPL_MASK;

   always_comb begin
      read_value = READ_ZERO;
      unique case (bus.addr)
         OFS_CHAN_MASK_SET: begin
            read_value = chan_mask;
         end
         OFS_CHAN_MASK_CLEAR: begin
            read_value = chan_mask;
         end
         OFS_EVENT_SET: begin
            read_value = masked_events;
         end
         OFS_EVENT_CLEAR: begin
            read_value = masked_events;
         end
         OFS_EVENT_RAW: begin
            read_value = events & EVENT_IMPL_MASK;
         end
         OFS_INT_MASK: begin
            read_value = int_mask;
         end
         OFS_CONTROL: begin
            read_value = control;
         end
         default: begin
            read_value = READ_ZERO;
         end
      endcase
   end

   assign bus.rdata = read_value;

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign channel_receive_enable_o = chan_mask;
   assign irq_o = |masked_events;

endmodule : iso_irq_regs

// file: hdl/iso_irq_pkg.sv
// Shared constants, types and helper functions for the channel mask and event block
package iso_irq_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SEL_W = 4;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CHAN_MASK_SET = 8'h78;
   localparam logic [ADDR_W-1:0] OFS_CHAN_MASK_CLEAR = 8'h7C;
   localparam logic [ADDR_W-1:0] OFS_EVENT_SET = 8'h80;
   localparam logic [ADDR_W-1:0] OFS_EVENT_CLEAR = 8'h84;
   localparam logic [ADDR_W-1:0] OFS_EVENT_RAW = 8'h88;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h8C;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h90;

   // ----------------------------------------------------------------
   // Event bit positions and layout
   // ----------------------------------------------------------------
   localparam int EV_GP_BIT = 30;
   localparam int EV_SOFT_BIT = 29;
   localparam int EV_LATE_BIT = 27;
   localparam logic [DATA_W-1:0] EVENT_IMPL_MASK = 32'h6800_0000;

   // ----------------------------------------------------------------
   // Control register layout
   // ----------------------------------------------------------------
   localparam int CTRL_LATE_EN_BIT = 0;
   localparam int CTRL_GP_A_EN_BIT = 1;
   localparam int CTRL_GP_B_EN_BIT = 2;
   localparam logic [DATA_W-1:0] CTRL_IMPL_MASK = 32'h0000_0007;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] CHAN_MASK_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] EVENT_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] INT_MASK_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Edge detector width
   // ----------------------------------------------------------------
   localparam int EDGE_W = 2;
   localparam int EDGE_GP = 0;
   localparam int EDGE_LATE = 1;

   // ----------------------------------------------------------------
   // Bus front states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_t;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [DATA_W-1:0] expand_sel(input logic [SEL_W-1:0] sel);
      logic [DATA_W-1:0] m;
      m = READ_ZERO;
      for (int i = 0; i < SEL_W; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction : expand_sel

   function automatic logic [DATA_W-1:0] set_clear(input logic [DATA_W-1:0] cur,
                                                   input logic [DATA_W-1:0] set,
                                                   input logic [DATA_W-1:0] clr);
      return (cur | set) & ~(clr & ~set);
   endfunction : set_clear

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] cur,
                                               input logic [DATA_W-1:0] wdata,
                                               input logic [DATA_W-1:0] wmask);
      return (cur & ~wmask) | (wdata & wmask);
   endfunction : merge

endpackage : iso_irq_pkg

// file: hdl/reg_access_if.sv
// Internal register access carrier between the bus front and the register file
interface reg_access_if;
   import iso_irq_pkg::*;

   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] wmask;
   logic [DATA_W-1:0] rdata;

   modport front (output wr, output addr, output wdata, output wmask, input rdata);
   modport regs (input wr, input addr, input wdata, input wmask, output rdata);
endinterface : reg_access_if

// file: hdl/wb_front.sv
// Classic Wishbone slave front end feeding the register file
module wb_front (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [iso_irq_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [iso_irq_pkg::SEL_W-1:0] wb_sel_i,
   input wire logic [iso_irq_pkg::DATA_W-1:0] wb_dat_i,
   output logic [iso_irq_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   reg_access_if.front bus
);
   import iso_irq_pkg::*;

   bus_state_t state;
   bus_state_t next_state;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] next_rdata_q;
   logic req;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign req = wb_cyc_i & wb_stb_i;
   assign bus.addr = {wb_adr_i[ADDR_W-1:2], WORD_ALIGN};
   assign bus.wdata = wb_dat_i;
   assign bus.wmask = expand_sel(wb_sel_i);
   assign bus.wr = req & wb_we_i & (state == BUS_ACK) & ce_i;
   assign wb_ack_o = (state == BUS_ACK) & req;
   assign wb_dat_o = rdata_q;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_rdata_q = rdata_q;
      unique case (state)
         BUS_IDLE: begin
            if (req) begin
               next_state = BUS_ACK;
               next_rdata_q = wb_we_i ? READ_ZERO : bus.rdata;
            end
         end
         BUS_ACK: begin
            next_state = BUS_IDLE;
         end
         default: begin
            next_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= BUS_IDLE;
         rdata_q <= READ_ZERO;
      end else if (ce_i) begin
         state <= next_state;
         rdata_q <= next_rdata_q;
      end
   end

endmodule : wb_front

// file: hdl/event_edge.sv
// Rising edge detector for event sources
module event_edge (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [iso_irq_pkg::EDGE_W-1:0] level_i,
   output logic [iso_irq_pkg::EDGE_W-1:0] rise_o
);
   import iso_irq_pkg::*;

   logic [EDGE_W-1:0] prev;
   logic [EDGE_W-1:0] next_prev;

   // ----------------------------------------------------------------
   // Previous level and edge
   // ----------------------------------------------------------------
   always_comb begin
      next_prev = level_i;
   end

   assign rise_o = level_i & ~prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev <= {EDGE_W{1'b0}};
      end else if (ce_i) begin
         prev <= next_prev;
      end
   end

endmodule : event_edge

// file: verif/iso_irq_monitor.sv
// Checker of bus timing, mask updates and interrupt behaviour
module iso_irq_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [iso_irq_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [iso_irq_pkg::SEL_W-1:0] wb_sel_i,
   input wire logic [iso_irq_pkg::DATA_W-1:0] wb_dat_i,
   input wire logic [iso_irq_pkg::DATA_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic gp_irq_a_i,
   input wire logic gp_irq_b_i,
   input wire logic rx_fifo_pending_i,
   input wire logic phys_resp_busy_i,
   input wire logic late_ack_sent_i,
   input wire logic [iso_irq_pkg::DATA_W-1:0] channel_receive_enable_o,
   input wire logic irq_o
);
   import iso_irq_pkg::*;
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   logic [4:0] src_q;
   logic [4:0] next_src_q;
   logic [4:0] src_rise;
   logic [DATA_W-1:0] bmask;

   always_comb begin
      next_src_q = {gp_irq_a_i, gp_irq_b_i, rx_fifo_pending_i, phys_resp_busy_i, late_ack_sent_i};
      src_rise = next_src_q & ~src_q;
      bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   end
   always_ff @(posedge clk_i) begin
      src_q <= next_src_q;
   end
   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence req_s;
      wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
   endsequence
   sequence wr_s(logic [7:0] ofs);
      wb_ack_o && wb_we_i && ce_i && wb_adr_i[7:2] == ofs[7:2];
   endsequence
   sequence rd_evt_s;
      wb_ack_o && !wb_we_i && wb_adr_i[7:3] == OFS_EVENT_SET[7:3];
   endsequence

   ack_follows_a: assert property (req_s |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   mask_set_a: assert property (wr_s(OFS_CHAN_MASK_SET) |=> channel_receive_enable_o ==
      ($past(channel_receive_enable_o) | ($past(wb_dat_i) & $past(bmask))))
      else $error("mask set write wrong");
   mask_clear_a: assert property (wr_s(OFS_CHAN_MASK_CLEAR) |=> channel_receive_enable_o ==
      ($past(channel_receive_enable_o) & ~($past(wb_dat_i) & $past(bmask))))
      else $error("mask clear write wrong");
   mask_hold_a: assert property (!$stable(channel_receive_enable_o) |->
      $past(wb_ack_o && wb_we_i && ce_i))
      else $error("channel enables changed without a write");
   irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
      else $error("interrupt dropped without a write");
   irq_rise_a: assert property ($rose(irq_o) |-> $past(wb_ack_o && wb_we_i) ||
      $past(wb_ack_o && wb_we_i, 2) || $past(|src_rise))
      else $error("interrupt rose without a cause");
   evt_resv_a: assert property (rd_evt_s |-> !wb_dat_o[31] && !wb_dat_o[28])
      else $error("reserved event bit read as one");
   evt_read_a: assert property (rd_evt_s |-> (wb_dat_o != '0) == $past(irq_o))
      else $error("event read disagrees with interrupt");
endmodule : iso_irq_monitor

bind iso_irq_regs iso_irq_monitor i_iso_irq_monitor (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .gp_irq_a_i, .gp_irq_b_i,
   .rx_fifo_pending_i, .phys_resp_busy_i, .late_ack_sent_i, .channel_receive_enable_o, .irq_o);

// file: verif/iso_irq_regs_test.sv
// Self-checking bench for the channel mask and event register block
module iso_irq_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import iso_irq_pkg::*;
   // ------------------------------------------------
   // Signals and design
   // ------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
   logic [ADDR_W-1:0] adr = '0, a;
   logic [SEL_W-1:0] sel = '0, s;
   logic [DATA_W-1:0] dat_w = '0, dat_r, chan, q, m, d, e, c;
   logic [4:0] src = '0;
   logic [7:0] regs [8] = '{8'h78, 8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h40};
   int failures = 0, n_tests = 0, seed = 55896;

   iso_irq_regs i_iso_irq_regs (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
      .wb_dat_o(dat_r), .wb_ack_o(ack), .gp_irq_a_i(src[0]), .gp_irq_b_i(src[1]),
      .rx_fifo_pending_i(src[2]), .phys_resp_busy_i(src[3]), .late_ack_sent_i(src[4]),
      .channel_receive_enable_o(chan), .irq_o(irq));

   initial begin
      forever #4 clk = ~clk;
   end
   // ------------------------------------------------
   // Tasks and functions
   // ------------------------------------------------
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [DATA_W-1:0] seen,
                        input logic [DATA_W-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wb(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd,
                     input logic [SEL_W-1:0] sd);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      dat_w <= dd;
      sel <= sd;
      do begin
         @(negedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      check("acknowledge", 32'(ack), 32'h1);
      q = dat_r;
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] exp, input string what);
      wb(1'b0, ad, '0, 4'hF);
      check(what, q, exp);
   endtask : rd

   function automatic logic [DATA_W-1:0] exp_mask(input logic [DATA_W-1:0] cur, input logic clr,
      input logic [DATA_W-1:0] dd, input logic [SEL_W-1:0] sd);
      logic [DATA_W-1:0] b;
      b = dd & {{8{sd[3]}}, {8{sd[2]}}, {8{sd[1]}}, {8{sd[0]}}};
      return clr ? (cur & ~b) : (cur | b);
   endfunction : exp_mask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      end_sim();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (regs[i]) rd(regs[i], '0, "reset value");
      m = '0;
      for (int i = 0; i < 24; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
         s = (i < 2) ? 4'hF : 4'($random(seed));
         a = (i == 1 || (i > 1 && d[0])) ? OFS_CHAN_MASK_CLEAR : OFS_CHAN_MASK_SET;
         wb(1'b1, a, d, s);
         m = exp_mask(m, a == OFS_CHAN_MASK_CLEAR, d, s);
         check("channel enables", chan, m);
         rd(OFS_CHAN_MASK_SET, m, "mask via set");
         rd(OFS_CHAN_MASK_CLEAR, m, "mask via clear");
      end
      wb(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
      check("mask after unmapped write", chan, m);
      rd(8'h40, '0, "unmapped read");
      wb(1'b1, OFS_INT_MASK, '1, 4'hF);
      wb(1'b1, OFS_EVENT_SET, 32'h2000_0000, 4'hF);
      rd(OFS_EVENT_RAW, 32'h2000_0000, "software event");
      check("irq set", 32'(irq), 32'h1);
      wb(1'b1, OFS_INT_MASK, '0, 4'hF);
      rd(OFS_EVENT_SET, '0, "masked event read");
      check("irq masked", 32'(irq), 32'h0);
      wb(1'b1, OFS_EVENT_SET, '0, 4'hF);
      wb(1'b1, OFS_EVENT_RAW, '1, 4'hF);
      rd(OFS_EVENT_RAW, 32'h2000_0000, "event kept");
      wb(1'b1, OFS_EVENT_CLEAR, 32'h2000_0000, 4'hF);
      rd(OFS_EVENT_RAW, '0, "event cleared");
      wb(1'b1, OFS_EVENT_SET, '1, 4'hF);
      d = $random(seed);
      wb(1'b1, OFS_INT_MASK, d, 4'hF);
      rd(OFS_EVENT_CLEAR, d & 32'h6800_0000, "events and mask");
      check("irq mask", 32'(irq), 32'(|(d & 32'h6800_0000)));
      wb(1'b1, OFS_INT_MASK, '1, 4'hF);
      rd(OFS_EVENT_SET, 32'h6800_0000, "reserved bits");
      wb(1'b1, OFS_EVENT_CLEAR, '1, 4'hF);
      for (int k = 0; k < 5; k++) begin
         e = (k < 2) ? 32'h4000_0000 : 32'h0800_0000;
         c = (k == 0) ? 32'h2 : (k == 1) ? 32'h4 : 32'h1;
         wb(1'b1, OFS_CONTROL, ~c & 32'h7, 4'hF);
         src[k] <= 1'b1;
         repeat (3) @(posedge clk);
         rd(OFS_EVENT_RAW, '0, "disabled source");
         src[k] <= 1'b0;
         wb(1'b1, OFS_CONTROL, c, 4'hF);
         src[k] <= 1'b1;
         repeat (3) @(posedge clk);
         rd(OFS_EVENT_RAW, e, "source event");
         check("irq source", 32'(irq), 32'h1);
         wb(1'b1, OFS_EVENT_CLEAR, e, 4'hF);
         rd(OFS_EVENT_RAW, '0, "level held");
         src[k] <= 1'b0;
         repeat (3) @(posedge clk);
         rd(OFS_EVENT_RAW, '0, "falling edge");
      end
      // Frozen clock enable: request neither answered nor written
      ce <= 1'b0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= 1'b1;
      adr <= OFS_CHAN_MASK_CLEAR;
      dat_w <= 32'hFFFF_FFFF;
      sel <= 4'hF;
      repeat (4) @(negedge clk);
      check("ack while frozen", 32'(ack), 32'h0);
      check("mask while frozen", chan, m);
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      check("mask after freeze", chan, m);
      rd(OFS_CHAN_MASK_SET, m, "mask read after freeze");
      end_sim();
   end
endmodule : iso_irq_regs_test
